// ===== common/nfh_params.svh
// timing and geometry constants for the nand host port
// assumes a 200 mhz system clock
`ifndef NFH_PARAMS_SVH
`define NFH_PARAMS_SVH
`define NFH_CLK_PERIOD_PS 5000
`define NFH_BYTE_CYCLE_NS 50
`define NFH_BYTE_CYCLES ((`NFH_BYTE_CYCLE_NS * 1000) / `NFH_CLK_PERIOD_PS)
`define NFH_HALF_CYCLES (`NFH_BYTE_CYCLES / 2)
`define NFH_PAGE_BYTES 528
`define NFH_MAIN_BYTES 512
`define NFH_SPARE_BYTES 16
`define NFH_PAGES_PER_BLOCK 16
`define NFH_BLOCKS 1024
`define NFH_ADDR_BYTES 3
`define NFH_CMD_READ_A 8'h00
`define NFH_CMD_READ_B 8'h01
`define NFH_CMD_READ_SPARE 8'h50
`define NFH_FIFO_DEPTH 4
`endif

// ===== common/nfh_pkg.sv
// types for the nand host port
// used by the host sequencer only
package nfh_pkg;
   typedef enum logic [3:0] {
      NFH_IDLE, NFH_CMD, NFH_ADDR, NFH_WAIT_BUSY, NFH_WAIT_READY,
      NFH_READ, NFH_DONE
   } nfh_state_t;
   typedef enum logic [1:0] {
      NFH_MODE_LOW, NFH_MODE_HIGH, NFH_MODE_SPARE
   } nfh_mode_t;
endpackage : nfh_pkg

// ===== core/nfh_fifo.sv
// small valid/ready fifo for read bytes
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module nfh_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // honest full and empty
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   // pointers and storage
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (clk_en) begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
      end
   end
endmodule : nfh_fifo

// ===== core/nfh_host.sv
// host sequencer driving a nand flash through its pins: read command,
// three address bytes, wait for ready, stream page bytes into a fifo.
// assumes the flash pins are wired directly, with a pull-up on ready/busy.
`timescale 1ns/1ps
`include "nfh_params.svh"
// Functional notes
// - command byte is latched on write strobe rising edge while command latch high.
// - address latch high makes write strobe bytes addresses, low makes them data.
// - spare area accessed only when spare select input enables it.
// - bytes stream at 50 ns per output strobe cycle.
// - command, address, data share the eight io lines.
// - read starts with 00h, 01h or 50h.
// - host sends three address bytes after the read command.
module nfh_host
   import nfh_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   // user request
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [1:0] req_mode,
   input wire logic [7:0] req_column,
   input wire logic [13:0] req_page,
   input wire logic [9:0] req_count,
   input wire logic req_write_protect,
   // user read data
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [7:0] rd_data,
   // flash pins
   output logic cmd_latch,
   output logic addr_latch,
   output logic chip_sel_n,
   output logic write_strobe_n,
   output logic output_strobe_n,
   output logic write_prot_n,
   output logic spare_zone_pick_n,
   input wire logic [7:0] shared_io_bus_in,
   output logic [7:0] shared_io_bus_out,
   output logic shared_io_bus_oe,
   input wire logic ready_busy
);
   localparam logic [7:0] HALF = 8'(`NFH_HALF_CYCLES);
   nfh_state_t state;
   nfh_state_t next_state;
   logic [7:0] tick;
   logic phase;
   logic [1:0] addr_idx;
   logic [9:0] remain;
   logic [21:0] addr_word;
   logic [1:0] mode;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [7:0] fifo_in_data;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   // half-cycle timer, each strobe phase lasts 25 ns
   wire tick_done = (tick == HALF - 8'h01);
   // read opcode from mode
   wire [7:0] read_opcode = (mode == NFH_MODE_SPARE) ? `NFH_CMD_READ_SPARE :
                            (mode == NFH_MODE_HIGH) ? `NFH_CMD_READ_B : `NFH_CMD_READ_A;
   // address byte select, column first then page low and high
   wire [7:0] addr_byte = (addr_idx == 2'd0) ? addr_word[7:0] :
                          (addr_idx == 2'd1) ? addr_word[15:8] : {2'b00, addr_word[21:16]};
   wire strobe_end = tick_done && phase;
   // stall reading when the fifo is full
   wire read_go = fifo_in_ready || phase;
   // next state
   always_comb begin
      next_state = state;
      case (state)
         NFH_IDLE: if (req_valid) next_state = NFH_CMD;
         NFH_CMD: if (strobe_end) next_state = NFH_ADDR;
         NFH_ADDR: if (strobe_end && addr_idx == 2'd2) next_state = NFH_WAIT_BUSY;
         NFH_WAIT_BUSY: if (!ready_busy || tick_done) next_state = NFH_WAIT_READY;
         NFH_WAIT_READY: if (ready_busy) next_state = NFH_READ;
         NFH_READ: if (strobe_end && remain == 10'd1) next_state = NFH_DONE;
         NFH_DONE: next_state = NFH_IDLE;
         default: next_state = NFH_IDLE;
      endcase
   end
   // request capture and address assembly
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         mode <= NFH_MODE_LOW;
         addr_word <= '0;
         remain <= '0;
         spare_zone_pick_n <= 1'b1;
         write_prot_n <= 1'b0;
      end else if (clk_en) begin
         write_prot_n <= !req_write_protect;
         if (state == NFH_IDLE && req_valid) begin
            mode <= nfh_mode_t'(req_mode);
            addr_word <= {req_page, req_column};
            remain <= (req_count == 10'd0) ? 10'd1 : req_count;
            spare_zone_pick_n <= (req_mode != NFH_MODE_SPARE);
         end else if (state == NFH_READ && strobe_end) begin
            remain <= remain - 10'd1;
         end
      end
   end
   // sequencer and strobe timing
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state <= NFH_IDLE;
         tick <= '0;
         phase <= 1'b0;
         addr_idx <= '0;
      end else if (clk_en) begin
         if (state != next_state) begin
            state <= next_state;
            tick <= '0;
            phase <= 1'b0;
         end else if (state != NFH_READ || read_go) begin
            tick <= tick_done ? 8'h00 : tick + 8'h01;
            if (tick_done) phase <= !phase;
         end
         if (state == NFH_ADDR && strobe_end) addr_idx <= addr_idx + 2'd1;
         if (state == NFH_IDLE) addr_idx <= '0;
      end
   end
   // pin drive, all from flip-flops
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cmd_latch <= 1'b0;
         addr_latch <= 1'b0;
         chip_sel_n <= 1'b1;
         write_strobe_n <= 1'b1;
         output_strobe_n <= 1'b1;
         shared_io_bus_out <= 8'h00;
         shared_io_bus_oe <= 1'b0;
      end else if (clk_en) begin
         cmd_latch <= (next_state == NFH_CMD);
         addr_latch <= (next_state == NFH_ADDR);
         chip_sel_n <= (next_state == NFH_IDLE);
         write_strobe_n <= !((next_state == state) && (state == NFH_CMD || state == NFH_ADDR) && !phase);
         output_strobe_n <= !((state == NFH_READ) && !phase && fifo_in_ready);
         shared_io_bus_oe <= (next_state == NFH_CMD || next_state == NFH_ADDR);
         shared_io_bus_out <= (state == NFH_ADDR) ? addr_byte : read_opcode;
      end
   end
   // push a byte at the end of each output strobe low phase
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         fifo_in_valid <= 1'b0;
         fifo_in_data <= 8'h00;
      end else if (clk_en) begin
         fifo_in_valid <= (state == NFH_READ) && tick_done && !phase && fifo_in_ready;
         fifo_in_data <= shared_io_bus_in;
      end
   end
   // user side registered
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         req_ready <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
      end else if (clk_en) begin
         req_ready <= (next_state == NFH_IDLE) && !(state == NFH_IDLE && req_valid);
         if (!rd_valid || rd_ready) begin
            rd_valid <= fifo_out_valid;
            rd_data <= fifo_out_data;
         end
      end
   end
   wire fifo_pop = fifo_out_valid && (!rd_valid || rd_ready);
   nfh_fifo #(.WIDTH(8), .DEPTH(`NFH_FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );
endmodule : nfh_host

// ===== testbench/nfh_host_chk.sv
// pin checker for the nand host port
// bound to nfh_host, one clock domain
`timescale 1ns/1ps
module nfh_host_chk (
   // clock, reset
   input logic clk_sys,
   input logic rst_b,
   input logic clk_en,
   // request and read stream
   input logic req_valid,
   input logic req_ready,
   input logic req_write_protect,
   input logic rd_valid,
   input logic rd_ready,
   input logic [7:0] rd_data,
   // flash pins
   input logic cmd_latch,
   input logic chip_sel_n,
   input logic write_strobe_n,
   input logic output_strobe_n,
   input logic write_prot_n,
   input logic [7:0] shared_io_bus_out,
   input logic shared_io_bus_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // pin and handshake relations
   a_oe_needs_sel: assert property (shared_io_bus_oe |-> !chip_sel_n)
      else $error("io drive without select");
   a_read_no_drive: assert property (!output_strobe_n |-> !shared_io_bus_oe && !chip_sel_n)
      else $error("host drives during read");
   a_write_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*5] ##1 write_strobe_n)
      else $error("write strobe width");
   a_read_width: assert property ($fell(output_strobe_n) |-> !output_strobe_n [*5] ##1 output_strobe_n)
      else $error("output strobe width");
   a_cmd_code: assert property ($rose(write_strobe_n) && cmd_latch |->
      shared_io_bus_oe && shared_io_bus_out inside {8'h00, 8'h01, 8'h50})
      else $error("bad command byte");
   a_wp_follows: assert property ($past(rst_b) && $past(clk_en) |-> write_prot_n == !$past(req_write_protect))
      else $error("write protect pin lags");
   a_take_once: assert property (req_valid && req_ready |=> !req_ready)
      else $error("request taken twice");
   a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("read byte dropped");
   // main scenarios
   c_cmd: cover property ($rose(write_strobe_n) && cmd_latch);
   c_stall: cover property (rd_valid && !rd_ready ##1 rd_valid);
   c_read: cover property ($fell(output_strobe_n));
endmodule : nfh_host_chk
bind nfh_host nfh_host_chk u_chk (.*);

// ===== testbench/nfh_flash_model.sv
// behavioural flash: latches, busy line, byte stream
// pins wired straight, pull-up on busy in the bench
`timescale 1ns/1ps
module nfh_flash_model (
   // host pins
   input logic cmd_latch,
   input logic addr_latch,
   input logic chip_sel_n,
   input logic write_strobe_n,
   input logic output_strobe_n,
   input logic spare_zone_pick_n,
   input logic [7:0] shared_io_bus_out,
   input logic [15:0] busy_ns,
   // flash answers
   output logic [7:0] io_drive,
   output logic rb_pull_low
);
   logic [7:0] op = 8'h00, q = 8'h00;
   logic [9:0] col = 10'h000;
   logic [13:0] pg = 14'h0000;
   int n = 0, bad_ops = 0;
   event load;
   initial rb_pull_low = 1'b0;
   // command and address capture
   always @(posedge write_strobe_n) begin
      if (!chip_sel_n && cmd_latch) begin
         op = shared_io_bus_out;
         n = 0;
         // only reads expected, so busy never stems from program or erase
         if (!(op inside {8'h00, 8'h01, 8'h50})) bad_ops++;
      end else if (!chip_sel_n && addr_latch) begin
         if (n == 0 && (op == 8'h50) == spare_zone_pick_n) bad_ops++;
         if (n == 1) pg[7:0] = shared_io_bus_out;
         if (n == 2) pg[13:8] = shared_io_bus_out[5:0];
         if (n == 0 && op == 8'h50 && !spare_zone_pick_n) col = {6'h20, shared_io_bus_out[3:0]};
         else if (n == 0) col = {1'b0, op == 8'h01, shared_io_bus_out};
         n++;
         if (n == 3) -> load;
      end
   end
   // page load holds busy low, open drain
   always @(load) begin : page_load
      rb_pull_low = 1'b1;
      #(busy_ns + 1); // release off the clock edge
      rb_pull_low = 1'b0;
   end
   // deselect during a page load abandons it
   always @(posedge chip_sel_n) if (rb_pull_low) begin
      disable page_load;
      rb_pull_low = 1'b0;
   end
   // next byte on strobe fall
   always @(negedge output_strobe_n) if (!chip_sel_n) begin
      q = col[7:0] ^ {col[9:8], 6'h00};
      col++;
   end
   // released bus shows the inverse of the last byte
   assign io_drive = (!chip_sel_n && !output_strobe_n) ? q : ~q;
endmodule : nfh_flash_model

// ===== testbench/tb.sv
// bench: host port against the behavioural flash
// one 200 mhz clock, checker bound in its own file
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, req_valid = 1'b0, rd_ready = 1'b0;
   logic req_write_protect = 1'b0, req_ready, rd_valid, cmd_latch, addr_latch, chip_sel_n;
   logic write_strobe_n, output_strobe_n, write_prot_n, spare_zone_pick_n, shared_io_bus_oe;
   logic rb_pull_low, ready_busy;
   logic [1:0] req_mode = 2'h0;
   logic [7:0] req_column = 8'h00, rd_data, shared_io_bus_out, shared_io_bus_in, io_drive;
   logic [9:0] req_count = 10'h000;
   logic [13:0] req_page = 14'h0123;
   logic [15:0] busy_ns = 16'h0064;
   int mismatches = 0, total_checks = 0;
   nfh_host dut (.*);
   nfh_flash_model u_flash (.*);
   // pull-up on busy, io wire resolved from both ends
   assign ready_busy = !rb_pull_low;
   assign shared_io_bus_in = shared_io_bus_oe ? shared_io_bus_out : io_drive;
   always #2.5 clk_sys = ~clk_sys;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // one read, bytes judged against the flash pattern
   task automatic run_read(input logic [1:0] m, input logic [7:0] c, input logic [9:0] n, input int stall);
      logic [9:0] a;
      int k = 0;
      a = m[1] ? {6'h20, c[3:0]} : {1'b0, m[0], c};
      @(posedge clk_sys);
      req_mode <= m;
      req_column <= c;
      req_count <= n;
      req_valid <= 1'b1;
      n = (n == 10'h000) ? 10'h001 : n;
      do @(negedge clk_sys); while (req_ready !== 1'b1 && ++k < 50);
      @(posedge clk_sys) req_valid <= 1'b0;
      repeat (stall) @(posedge clk_sys);
      rd_ready <= 1'b1;
      k = 0;
      for (int t = 0; t < 3000 && k < n; t++) begin
         @(negedge clk_sys);
         if (rd_valid === 1'b1) begin
            check(16'(rd_data), 16'(a[7:0] ^ {a[9:8], 6'h00}));
            a++;
            k++;
         end
      end
      check(16'(k), 16'(n));
      check(16'(u_flash.pg), 16'(req_page));
      check(16'(u_flash.bad_ops), 16'h0000);
      for (k = 0; k < 60 && chip_sel_n !== 1'b1; k++) @(negedge clk_sys);
      check(16'({chip_sel_n, ready_busy, write_prot_n}), 16'h0007);
      @(posedge clk_sys) rd_ready <= 1'b0;
   endtask : run_read
   // watchdog, far beyond the few reads below
   initial begin
      #200000;
      mismatches++;
      end_sim();
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      check(16'({chip_sel_n, write_strobe_n, output_strobe_n, shared_io_bus_oe, write_prot_n}), 16'h001c);
      run_read(2'h0, 8'hfe, 10'h003, 0);
      run_read(2'h1, 8'h10, 10'h006, 150);
      req_page <= 14'h2b7d;
      run_read(2'h2, 8'h0d, 10'h003, 0);
      busy_ns = 16'h07d0;
      run_read(2'h0, 8'h05, 10'h000, 0);
      @(posedge clk_sys) req_write_protect <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check(16'(write_prot_n), 16'h0000);
      // frozen enable keeps the pin while the request flips back
      @(posedge clk_sys) clk_en <= 1'b0;
      req_write_protect <= 1'b0;
      repeat (4) @(negedge clk_sys);
      check(16'(write_prot_n), 16'h0000);
      @(posedge clk_sys) clk_en <= 1'b1;
      repeat (2) @(negedge clk_sys);
      check(16'(write_prot_n), 16'h0001);
      end_sim();
   end
endmodule : tb
